// ---- design/scc_pkg.sv ----
/*
 * Package for the serial clock and select configuration block: register map,
 * field positions, reset values and the packed carriers shared by both files.
 * Assumes a 32-bit AXI4-Lite register bus and a single 125 MHz clock.
 */
package scc_pkg;

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [3:0] ADDR_CTRL_ONE   = 4'h0; // Master select, bit order
	localparam logic [3:0] ADDR_CTRL_TWO   = 4'h4; // serial_control_two
	localparam logic [3:0] ADDR_RATE       = 4'h8; // Prescale and rate codes
	localparam logic [3:0] ADDR_STATUS     = 4'hC; // Pin and clock state

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int BIT_MASTER_SELECT  = 0;
	localparam int BIT_LOW_FIRST      = 1;
	localparam int BIT_SELECT_OUT_EN  = 0; // In control two (bit 0 of 1:0 pair)
	localparam int BIT_MODE_FAULT_EN  = 4;
	localparam logic [7:0] CTRL_TWO_MASK = 8'h1B; // Bits 7,6,5,2 unimplemented
	localparam int RATE_LSB           = 0;
	localparam int PRESCALE_LSB       = 4;
	localparam int CODE_W             = 3;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] RST_CTRL_ONE = 8'h00;
	localparam logic [7:0] RST_CTRL_TWO = 8'h00;
	localparam logic [7:0] RST_RATE     = 8'h00;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Function selected for the slave-select pin
	typedef enum logic [1:0] {
		SEL_GPIO,
		SEL_FAULT_IN,
		SEL_AUTO_OUT,
		SEL_SLAVE_IN
	} scc_sel_mode_t;

	// Configuration handed from registers to the clock generator
	typedef struct packed {
		logic                master_select;
		logic                low_bit_first_enable;
		logic [CODE_W-1:0]   prescale_code;
		logic [CODE_W-1:0]   rate_divider_code;
	} scc_cfg_t;

endpackage

// ---- design/scc_rate_gen.sv ----
/*
 * Master bit-clock generator: prescaler by code+1, then power-of-two divider.
 * Assumes aclk is the bus clock; output is a level clock and a one-cycle tick.
 */
`timescale 1ns/1ps
`default_nettype none

module scc_rate_gen #(
	parameter int CODE_W = 3
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              run,
	input  wire logic [CODE_W-1:0] prescale_code,
	input  wire logic [CODE_W-1:0] rate_divider_code,
	output logic                   bit_clk,
	output logic                   bit_edge
);

	localparam int HALF_W = (1 << CODE_W) - 1; // Bit width of the half-period counter, enough for the largest rate code

	logic [CODE_W-1:0] pre_cnt_ff, nxt_pre_cnt;
	logic [HALF_W-1:0] half_cnt_ff, nxt_half_cnt;
	logic              clk_ff, nxt_clk;
	logic              edge_ff, nxt_edge;
	logic              pre_tick;
	logic [HALF_W-1:0] half_last;

	// ************************************************************
	// Prescaler and rate divider
	// ************************************************************
	// Rate divisor 2^(code+1) means toggling every 2^code prescaler ticks
	always_comb begin
		pre_tick     = (pre_cnt_ff == prescale_code); // [RULE6] [RULE10]
		half_last    = HALF_W'((1 << rate_divider_code) - 1); // [RULE7]
		nxt_pre_cnt  = pre_cnt_ff;
		nxt_half_cnt = half_cnt_ff;
		nxt_clk      = clk_ff;
		nxt_edge     = 1'b0;
		if (!run) begin
			nxt_pre_cnt  = '0;
			nxt_half_cnt = '0;
			nxt_clk      = 1'b0;
		end else begin
			nxt_pre_cnt = pre_tick ? '0 : pre_cnt_ff + 1'b1;
			if (pre_tick) begin // [RULE8]
				if (half_cnt_ff >= half_last) begin
					nxt_half_cnt = '0;
					nxt_clk      = ~clk_ff;
					nxt_edge     = 1'b1;
				end else begin
					nxt_half_cnt = half_cnt_ff + 1'b1;
				end
			end
		end
	end

	// Registers only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_cnt_ff  <= '0;
			half_cnt_ff <= '0;
			clk_ff      <= 1'b0;
			edge_ff     <= 1'b0;
		end else begin
			pre_cnt_ff  <= nxt_pre_cnt;
			half_cnt_ff <= nxt_half_cnt;
			clk_ff      <= nxt_clk;
			edge_ff     <= nxt_edge;
		end
	end

	assign bit_clk  = clk_ff;
	assign bit_edge = edge_ff;

endmodule

`default_nettype wire

// ---- design/scc_top.sv ----
/*
 * Clock and select configuration of a serial peripheral interface, with an
 * AXI4-Lite register slave. Assumes the shift engine sits outside and uses
 * bit_clk, low_bit_first and the select pin controls given here.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1: Master, fault disabled: select pin is plain GPIO, block leaves it alone.
// RULE2: Master, fault on, output off: select pin is a monitored fault input.
// RULE3: Master, fault on, output on: block drives select pin automatically.
// RULE4: Slave: select pin is always the select input, other bits ignored.
// RULE5: Bit-order bit 1 shifts LSB first, 0 shifts MSB first.
// RULE6: Prescaler divides by prescale code plus one, 1 to 8.
// RULE7: Rate divider divides by two to the power code plus one.
// RULE8: Prescaler feeds rate divider; its output is master bit clock.
// RULE9: Control two bits 7,6,5,2 read zero and ignore writes.
// RULE10: Prescaler input is the bus clock.
module scc_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        xfer_active,
	input  wire logic        select_assert,
	input  wire logic        slave_select_pin_in,
	output logic             slave_select_pin_out,
	output logic             slave_select_pin_oe_n,
	output logic             spi_owns_select,
	output logic             slave_selected,
	output logic             mode_fault,
	output logic             bit_clk,
	output logic             bit_edge,
	output logic             low_bit_first
);

	logic [7:0] ctrl1_ff, nxt_ctrl1;
	logic [7:0] ctrl2_ff, nxt_ctrl2;
	logic [7:0] rate_ff, nxt_rate;
	logic       aw_ff, nxt_aw;
	logic       w_ff, nxt_w;
	logic [3:0] awaddr_ff, nxt_awaddr;
	logic [7:0] wbyte_ff, nxt_wbyte;
	logic       wstrb0_ff, nxt_wstrb0;
	logic       bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic       rvalid_ff, nxt_rvalid;
	logic [1:0] rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;
	logic       ss_meta_ff, ss_sync_ff;
	logic       ss_out_ff, nxt_ss_out;
	logic       oe_n_ff, nxt_oe_n;
	logic       sel_ff, nxt_sel;
	logic       fault_ff, nxt_fault;
	logic       lsb_ff;
	scc_pkg::scc_cfg_t    cfg;
	scc_pkg::scc_sel_mode_t sel_mode;
	logic       do_write;

	// Mask of writable bits per register; unmapped offsets give none
	function automatic logic [7:0] wr_mask(input logic [3:0] a);
		unique case (a)
			scc_pkg::ADDR_CTRL_ONE: wr_mask = 8'h03;
			scc_pkg::ADDR_CTRL_TWO: wr_mask = scc_pkg::CTRL_TWO_MASK; // [RULE9]
			scc_pkg::ADDR_RATE:     wr_mask = 8'h77;
			default:                wr_mask = 8'h00;
		endcase
	endfunction

	function automatic logic is_mapped(input logic [3:0] a);
		is_mapped = (a == scc_pkg::ADDR_CTRL_ONE) || (a == scc_pkg::ADDR_CTRL_TWO) ||
			(a == scc_pkg::ADDR_RATE) || (a == scc_pkg::ADDR_STATUS);
	endfunction

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	// Address and data latched independently; response only once both held
	assign s_axi_awready = !aw_ff && !bvalid_ff;
	assign s_axi_wready  = !w_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign do_write      = aw_ff && w_ff && !bvalid_ff;

	always_comb begin
		nxt_aw     = aw_ff;
		nxt_w      = w_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wbyte  = wbyte_ff;
		nxt_wstrb0 = wstrb0_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp  = bresp_ff;
		nxt_ctrl1  = ctrl1_ff;
		nxt_ctrl2  = ctrl2_ff;
		nxt_rate   = rate_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw     = 1'b1;
			nxt_awaddr = {s_axi_awaddr[3:2], 2'h0};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w      = 1'b1;
			nxt_wbyte  = s_axi_wdata[7:0];
			nxt_wstrb0 = s_axi_wstrb[0];
		end
		if (do_write) begin
			nxt_aw     = 1'b0;
			nxt_w      = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp  = is_mapped(awaddr_ff) ? scc_pkg::RESP_OKAY : scc_pkg::RESP_SLVERR;
			if (wstrb0_ff) begin
				unique case (awaddr_ff)
					scc_pkg::ADDR_CTRL_ONE: nxt_ctrl1 = wbyte_ff & wr_mask(awaddr_ff);
					scc_pkg::ADDR_CTRL_TWO: nxt_ctrl2 = wbyte_ff & wr_mask(awaddr_ff); // [RULE9]
					scc_pkg::ADDR_RATE:     nxt_rate  = wbyte_ff & wr_mask(awaddr_ff);
					default:                ; // Status is read-only, write dropped
				endcase
			end
		end
		if (bvalid_ff && s_axi_bready)
			nxt_bvalid = 1'b0;
	end

	// Read path: data registered one cycle after the address is taken
	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rresp  = rresp_ff;
		nxt_rdata  = rdata_ff;
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = is_mapped(s_axi_araddr) ? scc_pkg::RESP_OKAY : scc_pkg::RESP_SLVERR;
			unique case ({s_axi_araddr[3:2], 2'h0})
				scc_pkg::ADDR_CTRL_ONE: nxt_rdata = {24'h0, ctrl1_ff};
				scc_pkg::ADDR_CTRL_TWO: nxt_rdata = {24'h0, ctrl2_ff & scc_pkg::CTRL_TWO_MASK}; // [RULE9]
				scc_pkg::ADDR_RATE:     nxt_rdata = {24'h0, rate_ff};
				default:                nxt_rdata = {26'h0, mode_fault, slave_selected,
					spi_owns_select, bit_clk, sel_mode};
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awaddr_ff <= 4'h0;
			wbyte_ff  <= 8'h00;
			wstrb0_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= scc_pkg::RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff  <= scc_pkg::RESP_OKAY;
			rdata_ff  <= 32'h0;
			ctrl1_ff  <= scc_pkg::RST_CTRL_ONE;
			ctrl2_ff  <= scc_pkg::RST_CTRL_TWO;
			rate_ff   <= scc_pkg::RST_RATE;
		end else begin
			aw_ff     <= nxt_aw;
			w_ff      <= nxt_w;
			awaddr_ff <= nxt_awaddr;
			wbyte_ff  <= nxt_wbyte;
			wstrb0_ff <= nxt_wstrb0;
			bvalid_ff <= nxt_bvalid;
			bresp_ff  <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rresp_ff  <= nxt_rresp;
			rdata_ff  <= nxt_rdata;
			ctrl1_ff  <= nxt_ctrl1;
			ctrl2_ff  <= nxt_ctrl2;
			rate_ff   <= nxt_rate;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp  = rresp_ff;
	assign s_axi_rdata  = rdata_ff;

	// ************************************************************
	// Configuration and pin function
	// ************************************************************
	// One process drives the whole carrier so it has a single driver
	always_comb begin
		cfg.master_select        = ctrl1_ff[scc_pkg::BIT_MASTER_SELECT];
		cfg.low_bit_first_enable = ctrl1_ff[scc_pkg::BIT_LOW_FIRST];
		cfg.prescale_code        = rate_ff[scc_pkg::PRESCALE_LSB +: scc_pkg::CODE_W];
		cfg.rate_divider_code    = rate_ff[scc_pkg::RATE_LSB +: scc_pkg::CODE_W];
	end

	// Pin function decode; slave mode ignores both enables
	always_comb begin
		if (!cfg.master_select)
			sel_mode = scc_pkg::SEL_SLAVE_IN; // [RULE4]
		else if (!ctrl2_ff[scc_pkg::BIT_MODE_FAULT_EN])
			sel_mode = scc_pkg::SEL_GPIO; // [RULE1]
		else if (!ctrl2_ff[scc_pkg::BIT_SELECT_OUT_EN])
			sel_mode = scc_pkg::SEL_FAULT_IN; // [RULE2]
		else
			sel_mode = scc_pkg::SEL_AUTO_OUT; // [RULE3]
	end

	// Pin level passes two flops before use; fault is sticky until master drops
	always_comb begin
		nxt_ss_out = 1'b1;
		nxt_oe_n   = 1'b1;
		nxt_sel    = 1'b0;
		nxt_fault  = fault_ff && cfg.master_select;
		unique case (sel_mode)
			scc_pkg::SEL_AUTO_OUT: begin
				nxt_oe_n   = 1'b0; // [RULE3]
				nxt_ss_out = !select_assert;
			end
			scc_pkg::SEL_FAULT_IN: nxt_fault = fault_ff || !ss_sync_ff; // [RULE2]
			scc_pkg::SEL_SLAVE_IN: nxt_sel = !ss_sync_ff; // [RULE4]
			scc_pkg::SEL_GPIO:     nxt_sel = 1'b0; // [RULE1]
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ss_meta_ff <= 1'b1;
			ss_sync_ff <= 1'b1;
			ss_out_ff  <= 1'b1;
			oe_n_ff    <= 1'b1;
			sel_ff     <= 1'b0;
			fault_ff   <= 1'b0;
			lsb_ff     <= 1'b0;
		end else begin
			ss_meta_ff <= slave_select_pin_in;
			ss_sync_ff <= ss_meta_ff;
			ss_out_ff  <= nxt_ss_out;
			oe_n_ff    <= nxt_oe_n;
			sel_ff     <= nxt_sel;
			fault_ff   <= nxt_fault;
			lsb_ff     <= cfg.low_bit_first_enable; // [RULE5]
		end
	end

	assign slave_select_pin_out  = ss_out_ff;
	assign slave_select_pin_oe_n = oe_n_ff;
	assign spi_owns_select       = (sel_mode != scc_pkg::SEL_GPIO); // [RULE1]
	assign slave_selected        = sel_ff;
	assign mode_fault            = fault_ff;
	assign low_bit_first         = lsb_ff;

	// ************************************************************
	// Master bit clock
	// ************************************************************
	scc_rate_gen #(
		.CODE_W (scc_pkg::CODE_W)
	) u_rate (
		.aclk              (aclk),
		.aresetn           (aresetn),
		.run               (cfg.master_select && xfer_active), // [RULE8]
		.prescale_code     (cfg.prescale_code),
		.rate_divider_code (cfg.rate_divider_code),
		.bit_clk           (bit_clk),
		.bit_edge          (bit_edge)
	);

endmodule

`default_nettype wire

// ---- test/scc_top_monitor.sv ----
/* Port checker for scc_top.
 * Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module scc_top_monitor (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        xfer_active,
	input wire logic        select_assert,
	input wire logic        slave_select_pin_in,
	input wire logic        slave_select_pin_out,
	input wire logic        slave_select_pin_oe_n,
	input wire logic        slave_selected,
	input wire logic        mode_fault,
	input wire logic        bit_clk
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Both write items taken at one edge
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Three cycles of an asked-for select, long enough to cover the register lag
	sequence drive_req;
		(!slave_select_pin_oe_n && select_assert) [*3];
	endsequence
	// Items held one cycle, response registered the next
	a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("no write response");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
	a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_auto_drive: assert property (drive_req |-> !slave_select_pin_out)
		else $error("select not driven");
	a_release_high: assert property (slave_select_pin_oe_n [*2] |-> slave_select_pin_out)
		else $error("pin drive not idle");
	a_slave_no_drive: assert property (slave_selected |-> slave_select_pin_oe_n)
		else $error("slave drives select");
	a_fault_input: assert property ($rose(mode_fault) |-> slave_select_pin_oe_n &&
		(!$past(slave_select_pin_in, 2) || !$past(slave_select_pin_in, 3) || !$past(slave_select_pin_in, 4)))
		else $error("fault without low pin");
	a_clk_stops: assert property ((!xfer_active) [*4] |-> !bit_clk)
		else $error("bit clock runs idle");
endmodule
bind scc_top scc_top_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .xfer_active(xfer_active), .select_assert(select_assert),
	.slave_select_pin_in(slave_select_pin_in), .slave_select_pin_out(slave_select_pin_out),
	.slave_select_pin_oe_n(slave_select_pin_oe_n), .slave_selected(slave_selected),
	.mode_fault(mode_fault), .bit_clk(bit_clk));
`default_nettype wire

// ---- test/scc_spi_peer.sv ----
/* Behavioural SPI peer on the select pin.
 * Assumes a pull-up on the pin; the bench sets whether the peer pulls it low. */
`timescale 1ns/1ps
`default_nettype none
module scc_spi_peer (
	input wire logic pin_out,
	input wire logic pin_oe_n,
	input wire logic pull_low,
	output logic     pin_level,
	output logic     selected
);
	// Block drive wins; otherwise the peer or the pull-up sets the level
	assign pin_level = !pin_oe_n ? pin_out : !pull_low;
	assign selected  = !pin_level;
endmodule
`default_nettype wire

// ---- test/spi_clock_and_select_config_test.sv ----
/* Self-checking bench for scc_top with an SPI peer on the select pin.
 * Assumes the register map and timing given in scc_pkg. */
`timescale 1ns/1ps
`default_nettype none
module spi_clock_and_select_config_test;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic xfer = 0, sel_req = 0, pull = 0, pin, peer_sel, oe_n, pout, owns, ssel, flt, bclk, lsb;
	logic [3:0] awa = 0, ara = 0;
	logic [31:0] wd = 0;
	wire logic awr, wr_r, bv, arr, rv, edg;
	wire logic [1:0] br, rr;
	wire logic [31:0] rd_d;
	logic [33:0] q[$];
	int n_fail = 0, n_compared = 0, seed = 3, n, ne;
	logic m, f, o;
	logic [7:0] v;
	always #4 aclk = ~aclk;
	scc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .xfer_active(xfer),
		.select_assert(sel_req), .slave_select_pin_in(pin), .slave_select_pin_out(pout),
		.slave_select_pin_oe_n(oe_n), .spi_owns_select(owns), .slave_selected(ssel), .mode_fault(flt),
		.bit_clk(bclk), .bit_edge(edg), .low_bit_first(lsb));
	scc_spi_peer peer (.pin_out(pout), .pin_oe_n(oe_n), .pull_low(pull), .pin_level(pin), .selected(peer_sel));
	// ****************************************
	// Bus tasks and checking
	// ****************************************
	task chk(input logic [33:0] seen, input logic [33:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 0;
			if (wr_r) wv <= 0;
		end while (!(awr && wr_r) && (awv || wv));
		while (!bv) @(posedge aclk);
		chk(br, scc_pkg::RESP_OKAY);
		bry <= 0;
	endtask
	// Expected read result is queued; the watcher below compares it
	task rd(input logic [3:0] a, input logic [33:0] exp);
		q.push_back(exp);
		@(posedge aclk);
		ara <= a; arv <= 1; rry <= 1;
		do @(posedge aclk); while (!arr);
		arv <= 0;
		while (!rv) @(posedge aclk);
		rry <= 0;
	endtask
	always @(posedge aclk) if (rv && rry) chk({rr, rd_d}, q.pop_front());
	task end_sim;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Cycles between two toggles of the bit clock, skipping the first partial one
	// Also counts bit_edge pulses seen over that span: exactly one is expected
	task period(output int c, output int e);
		logic b;
		b = bclk;
		do @(posedge aclk); while (bclk === b);
		b = bclk;
		c = 0;
		e = 0;
		do begin
			@(posedge aclk);
			c++;
			e += (edg === 1'b1);
		end while (bclk === b && c < 5000);
	endtask
	initial begin #500000; n_fail++; end_sim; end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		rd(scc_pkg::ADDR_CTRL_TWO, 34'h0);
		rd(4'h6, {scc_pkg::RESP_SLVERR, 32'h0});
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? 8'hFF : 8'($random(seed));
			wr(scc_pkg::ADDR_CTRL_TWO, {24'($random(seed)), v});
			rd(scc_pkg::ADDR_CTRL_TWO, 34'(v & scc_pkg::CTRL_TWO_MASK));
		end
		$display("reserved bits done");
		for (int i = 0; i < 8; i++) begin
			{m, f, o} = 3'(i);
			wr(scc_pkg::ADDR_CTRL_TWO, {27'h0, f, 3'h0, o});
			wr(scc_pkg::ADDR_CTRL_ONE, {31'h0, m});
			v = m ? (f ? (o ? 8'h0A : 8'h09) : 8'h00) : 8'h0B;
			rd(scc_pkg::ADDR_STATUS, 34'(v));
			chk(oe_n, !(m && f && o));
			chk(owns, !(m && !f));
		end
		$display("pin modes done");
		wr(scc_pkg::ADDR_CTRL_TWO, 32'h10);
		wr(scc_pkg::ADDR_CTRL_ONE, 32'h1);
		pull <= 1;
		repeat (6) @(posedge aclk);
		pull <= 0;
		rd(scc_pkg::ADDR_STATUS, 34'h29);
		chk(flt, 1'b1);
		wr(scc_pkg::ADDR_CTRL_ONE, 32'h0);
		pull <= 1;
		repeat (6) @(posedge aclk);
		rd(scc_pkg::ADDR_STATUS, 34'h1B);
		chk({flt, ssel, oe_n}, 3'b011);
		pull <= 0;
		$display("fault and slave done");
		wr(scc_pkg::ADDR_CTRL_TWO, 32'h11);
		wr(scc_pkg::ADDR_CTRL_ONE, 32'h3);
		for (int i = 1; i >= 0; i--) begin
			sel_req <= i[0];
			repeat (5) @(posedge aclk);
			chk({pout, peer_sel, lsb}, {!i[0], i[0], 1'b1});
		end
		wr(scc_pkg::ADDR_CTRL_ONE, 32'h1);
		rd(scc_pkg::ADDR_CTRL_ONE, 34'h1);
		chk(lsb, 1'b0);
		$display("select drive and order done");
		xfer <= 1;
		for (int i = 0; i < 16; i++) begin
			wr(scc_pkg::ADDR_RATE, {25'h0, 3'(i % 8), 1'b0, 3'(i / 2)});
			period(n, ne);
			chk(34'(n), 34'(((i % 8) + 1) << (i / 2)));
			chk(34'(ne), 34'h1);
		end
		xfer <= 0;
		repeat (6) @(posedge aclk);
		chk(bclk, 1'b0);
		$display("rates done");
		// Mid-run reset must bring registers and pin drive back to idle
		aresetn <= 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		rd(scc_pkg::ADDR_RATE, 34'(scc_pkg::RST_RATE));
		rd(scc_pkg::ADDR_CTRL_ONE, 34'(scc_pkg::RST_CTRL_ONE));
		chk({oe_n, pout, flt}, 3'b110);
		$display("mid-run reset done");
		end_sim;
	end
endmodule
`default_nettype wire
